// ### hdl/lcs_pkg.sv
// shared constants and types for the l2 cache snoop controller
package lcs_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL_ONE = 8'h02;
  localparam logic [7:0] IDX_TAG_TEST = 8'h07;
  localparam logic [7:0] IDX_STATUS = 8'h08;
  localparam logic [7:0] IDX_FILTER = 8'h09;
  // reset values
  localparam logic [7:0] RST_CTRL_ONE = 8'h00;
  localparam logic [7:0] RST_TAG_TEST = 8'h00;
  localparam logic [7:0] RST_FILTER = 8'h00;
  // field positions
  localparam int OP_LSB = 2;
  localparam int POLICY_LSB = 4;
  localparam int FILTER_EN_BIT = 0;
  localparam int CHUNK_LSB = 3;
  localparam int LINE_W = 5;
  localparam int TAG_W = 8;
  // operation field and write policy codes
  localparam logic [1:0] OP_DISABLE = 2'h0;
  localparam logic [1:0] OP_TAG_WRITE = 2'h1;
  localparam logic [1:0] OP_TAG_READ = 2'h2;
  localparam logic [1:0] OP_ENABLE = 2'h3;
  localparam logic [1:0] POLICY_WTHRU = 2'h3;
  // timing in processor clocks
  localparam logic [2:0] MODIFIED_HIT_N_WINDOW = 3'h4;
  localparam logic [1:0] LAST_BEAT = 2'h3;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    CMD_DRAM_RD, CMD_DRAM_WR, CMD_L2_RD, CMD_L2_WR
  } lcs_cmd_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_CPU_CASTOUT, ST_CPU_FILL, ST_CPU_L2, ST_CPU_DRAM,
    ST_SN_BACKOFF, ST_SN_STROBE, ST_SN_WAIT, ST_SN_CASTOUT,
    ST_MST_MEM, ST_MST_L2W, ST_RELEASE
  } lcs_state_t;
endpackage

// ### hdl/lcs_reg_if.sv
// carrier between register file and snoop core
`timescale 1ns/1ns
interface lcs_reg_if;
  logic [7:0] ctrlOne;
  logic [7:0] tagTest;
  logic [7:0] filterCtrl;
  logic [7:0] status;
  logic capValid;
  logic [7:0] capData;
  modport regs (output ctrlOne, tagTest, filterCtrl,
    input status, capValid, capData);
  modport core (input ctrlOne, tagTest, filterCtrl,
    output status, capValid, capData);
endinterface

// ### hdl/lcs_tag_store.sv
// tag and dirty ram, one entry per cache line
`timescale 1ns/1ns
module lcs_tag_store #(
  parameter int INDEX_W = 10,
  parameter int TW = 8
) (
  // clock
  input wire logic clk,
  // lookup
  input wire logic [INDEX_W-1:0] rdIndex,
  output logic [TW-1:0] rdTag,
  output logic rdDirty,
  // update
  input wire logic wrEn,
  input wire logic [INDEX_W-1:0] wrIndex,
  input wire logic [TW-1:0] wrTag,
  input wire logic wrDirty
);
  // no reset: contents are random until software initialises them
  logic [TW:0] mem [2**INDEX_W];

  // asynchronous read keeps the hit decision in the request cycle
  assign {rdDirty, rdTag} = mem[rdIndex];

  // single write port
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrIndex] <= {wrDirty, wrTag};
    end
  end
endmodule // lcs_tag_store

// ### hdl/lcs_axil_regs.sv
// axi4-lite slave holding the control, tag test and filter registers
`timescale 1ns/1ns
module lcs_axil_regs import lcs_pkg::*; #(
  parameter int AW = 8
) (
  // system
  input wire logic clk,
  input wire logic rst,
  // write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [AW-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [AW-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // core side
  lcs_reg_if.regs core
);
  logic [7:0] ctrl_reg, tagTest_reg, filter_reg;
  logic awHeld_reg, wHeld_reg;
  logic [AW-1:0] awAddr_reg;
  logic [7:0] wData_reg;
  logic wLane_reg;
  logic doWrite;
  logic [7:0] wIdx;

  // byte address to register index; misaligned maps nowhere
  function automatic logic [7:0] regIdx(input logic [AW-1:0] a);
    return (a[1:0] == 2'h0) ? 8'(a >> 2) : 8'hff;
  endfunction

  assign awready = !awHeld_reg;
  assign wready = !wHeld_reg;
  assign arready = !rvalid;
  assign doWrite = awHeld_reg && wHeld_reg && !bvalid;
  assign wIdx = regIdx(awAddr_reg);
  assign core.ctrlOne = ctrl_reg;
  assign core.tagTest = tagTest_reg;
  assign core.filterCtrl = filter_reg;

  // address and data are caught independently, in either order
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= '0;
      wData_reg <= 8'h00;
      wLane_reg <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end else if (doWrite) begin
        awHeld_reg <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata[7:0];
        wLane_reg <= wstrb[0];
      end else if (doWrite) begin
        wHeld_reg <= 1'b0;
      end
    end
  end

  // register stores; a tag capture wins over a software write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= RST_CTRL_ONE;
      tagTest_reg <= RST_TAG_TEST;
      filter_reg <= RST_FILTER;
    end else begin
      if (doWrite && wLane_reg) begin
        if (wIdx == IDX_CTRL_ONE) ctrl_reg <= wData_reg;
        if (wIdx == IDX_TAG_TEST) tagTest_reg <= wData_reg;
        if (wIdx == IDX_FILTER) filter_reg <= wData_reg;
      end
      if (core.capValid) tagTest_reg <= core.capData;
    end
  end

  // write response; the status register is read only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp <= (wIdx == IDX_CTRL_ONE || wIdx == IDX_TAG_TEST ||
        wIdx == IDX_FILTER) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read data, unmapped reads return zero with slverr
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      unique case (regIdx(araddr))
        IDX_CTRL_ONE: rdata <= {24'h0, ctrl_reg};
        IDX_TAG_TEST: rdata <= {24'h0, tagTest_reg};
        IDX_STATUS: rdata <= {24'h0, core.status};
        IDX_FILTER: rdata <= {24'h0, filter_reg};
        default: begin
          rdata <= 32'h0;
          rresp <= RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule // lcs_axil_regs

// ### hdl/lcs_snoop_ctrl.sv
// l2 cache controller: test modes, castouts and bus master snooping
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
module lcs_snoop_ctrl import lcs_pkg::*; #(
  parameter int ADDR_W = 32,
  parameter int INDEX_W = 10,
  parameter int AW = 8
) (
  // system
  input wire logic clk,
  input wire logic rst,
  // axi4-lite register slave
  input wire logic awvalid,
  output logic awready,
  input wire logic [AW-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [AW-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // processor bus pins
  output logic busBackoffN,
  input wire logic holdAcknowledge,
  output logic addressHold,
  output logic externalSnoopStrobeN,
  input wire logic modifiedHitN,
  input wire logic castoutBeat,
  output logic [ADDR_W-1:0] snoopAddr,
  output logic snoopAddrOe,
  output logic snoopInvalidate,
  // processor cycles reaching the cache
  input wire logic cpuReqValid,
  input wire logic cpuReqWrite,
  input wire logic [ADDR_W-1:0] cpuReqAddr,
  output logic cpuReqDone,
  // bus master cycles
  input wire logic mstReqValid,
  input wire logic mstReqWrite,
  input wire logic [ADDR_W-1:0] mstReqAddr,
  output logic mstReqDone,
  // memory and sram command port
  output logic cmdValid,
  output lcs_cmd_t cmdKind,
  output logic [ADDR_W-1:0] cmdAddr,
  input wire logic cmdDone
);
  localparam int TAG_LSB = LINE_W + INDEX_W;

  lcs_reg_if regs ();
  lcs_state_t state_reg, cpuNext;
  logic [2:0] syncA_reg, syncB_reg;
  logic beatDly_reg, beatPend_reg;
  logic [ADDR_W-1:0] addr_reg, lookupAddr;
  logic wr_reg, l2Hit_reg, snooped_reg, modifiedLineHit_reg;
  logic [TAG_W-1:0] vicTag_reg, rdTag, tagWrTag;
  logic [1:0] beat_reg;
  logic [2:0] wait_reg;
  logic [ADDR_W-LINE_W-1:0] filtLine_reg;
  logic filtValid_reg;
  logic rdDirty, tagWrEn, tagWrDirty, l2Hit, filterHit;
  logic cpuTake, mstTake, holdAckSync, hitMSync, beatSync, opDone;
  logic [1:0] opField;
  logic wthru;

  function automatic logic [TAG_W-1:0] tagOf(input logic [ADDR_W-1:0] a);
    return a[TAG_LSB +: TAG_W];
  endfunction
  function automatic logic [INDEX_W-1:0] indexOf(input logic [ADDR_W-1:0] a);
    return a[LINE_W +: INDEX_W];
  endfunction

  lcs_axil_regs #(.AW(AW)) u_regs (
    .clk(clk), .rst(rst),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .core(regs.regs)
  );

  lcs_tag_store #(.INDEX_W(INDEX_W), .TW(TAG_W)) u_tags (
    .clk(clk), .rdIndex(indexOf(lookupAddr)), .rdTag(rdTag),
    .rdDirty(rdDirty), .wrEn(tagWrEn), .wrIndex(indexOf(lookupAddr)),
    .wrTag(tagWrTag), .wrDirty(tagWrDirty)
  );

  // pin synchronisers: stage one feeds stage two only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA_reg <= 3'h2;
      syncB_reg <= 3'h2;
      beatDly_reg <= 1'b0;
    end else begin
      syncA_reg <= {castoutBeat, modifiedHitN, holdAcknowledge};
      syncB_reg <= syncA_reg;
      beatDly_reg <= syncB_reg[2];
    end
  end
  assign holdAckSync = syncB_reg[0];
  assign hitMSync = !syncB_reg[1];
  assign beatSync = syncB_reg[2] && !beatDly_reg;

  // decode of the control register
  assign opField = regs.ctrlOne[OP_LSB +: 2];
  assign wthru = regs.ctrlOne[POLICY_LSB +: 2] == POLICY_WTHRU;
  assign cpuTake = state_reg == ST_IDLE && !mstReqValid && cpuReqValid;
  assign mstTake = state_reg == ST_IDLE && mstReqValid;
  assign lookupAddr = (state_reg != ST_IDLE) ? addr_reg :
    (mstReqValid ? mstReqAddr : cpuReqAddr);
  assign l2Hit = opField == OP_ENABLE && rdTag == tagOf(lookupAddr);
  assign filterHit = regs.filterCtrl[FILTER_EN_BIT] && filtValid_reg &&
    filtLine_reg == mstReqAddr[ADDR_W-1:LINE_W];
  assign opDone = cmdValid && cmdDone;

  always_comb begin
    cpuNext = ST_CPU_DRAM;
    if (opField == OP_ENABLE) begin
      if (l2Hit) begin
        cpuNext = ST_CPU_L2;
      // dirty victim goes out first; write-through ignores dirty
      end else if (!cpuReqWrite) begin
        cpuNext = (rdDirty && !wthru) ? ST_CPU_CASTOUT : ST_CPU_FILL;
      end
    end
  end

  // tag updates: test writes, linefills and writeback dirty marking
  always_comb begin
    tagWrEn = 1'b0;
    tagWrTag = tagOf(addr_reg);
    tagWrDirty = 1'b0;
    // tag test value replaces the tag
    if (cpuTake && opField == OP_TAG_WRITE) begin
      tagWrEn = 1'b1;
      tagWrTag = regs.tagTest;
    end else if (state_reg == ST_CPU_FILL && opDone) begin
      tagWrEn = 1'b1;
    end else if (state_reg == ST_CPU_L2 && opDone && wr_reg && !wthru) begin
      tagWrEn = 1'b1;
      tagWrDirty = 1'b1;
    end
  end
  assign regs.capValid = cpuTake && opField == OP_TAG_READ;
  assign regs.capData = rdTag;

  // memory and sram commands per state
  always_comb begin
    cmdValid = 1'b0;
    cmdKind = CMD_DRAM_RD;
    cmdAddr = addr_reg;
    unique case (state_reg)
      ST_CPU_CASTOUT: begin
        cmdValid = 1'b1;
        cmdKind = CMD_DRAM_WR;
        cmdAddr[TAG_LSB +: TAG_W] = vicTag_reg;
        cmdAddr[LINE_W-1:0] = '0;
      end
      ST_CPU_FILL: cmdValid = 1'b1;
      ST_CPU_L2: begin
        cmdValid = 1'b1;
        cmdKind = wr_reg ? CMD_L2_WR : CMD_L2_RD;
      end
      ST_CPU_DRAM: begin
        cmdValid = 1'b1;
        cmdKind = wr_reg ? CMD_DRAM_WR : CMD_DRAM_RD;
      end
      // castout beats in processor burst order
      ST_SN_CASTOUT: begin
        cmdValid = beatPend_reg;
        cmdKind = l2Hit_reg ? CMD_L2_WR : CMD_DRAM_WR;
        cmdAddr[LINE_W-1:0] = '0;
        cmdAddr[CHUNK_LSB +: 2] = addr_reg[CHUNK_LSB +: 2] ^ beat_reg;
      end
      // read source and write-through to dram
      ST_MST_MEM: begin
        cmdValid = 1'b1;
        cmdKind = wr_reg ? CMD_DRAM_WR : (l2Hit_reg ? CMD_L2_RD : CMD_DRAM_RD);
      end
      ST_MST_L2W: begin
        cmdValid = 1'b1;
        cmdKind = CMD_L2_WR;
      end
      default: ;
    endcase
  end

  // main sequencer; bus masters take priority over the processor
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (mstReqValid) state_reg <= filterHit ? ST_MST_MEM : ST_SN_BACKOFF;
          else if (cpuReqValid) state_reg <= cpuNext;
        end
        ST_CPU_CASTOUT: if (cmdDone) state_reg <= ST_CPU_FILL;
        ST_CPU_L2: begin
          if (cmdDone) state_reg <= (wr_reg && wthru) ? ST_CPU_DRAM : ST_IDLE;
        end
        ST_CPU_FILL, ST_CPU_DRAM: if (cmdDone) state_reg <= ST_IDLE;
        // wait for the processor to hand over the bus
        ST_SN_BACKOFF: if (holdAckSync) state_reg <= ST_SN_STROBE;
        ST_SN_STROBE: state_reg <= ST_SN_WAIT;
        // modified hit means a castout follows
        ST_SN_WAIT: begin
          if (hitMSync) state_reg <= ST_SN_CASTOUT;
          else if (wait_reg == 3'h0) state_reg <= ST_MST_MEM;
        end
        ST_SN_CASTOUT: begin
          if (opDone && beat_reg == LAST_BEAT) state_reg <= ST_MST_MEM;
        end
        ST_MST_MEM: begin
          if (cmdDone) state_reg <= (wr_reg && l2Hit_reg) ? ST_MST_L2W : ST_RELEASE;
        end
        ST_MST_L2W: if (cmdDone) state_reg <= ST_RELEASE;
        ST_RELEASE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // cycle context captured when a request is taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_reg <= '0;
      wr_reg <= 1'b0;
      l2Hit_reg <= 1'b0;
      vicTag_reg <= '0;
      snooped_reg <= 1'b0;
    end else if (mstTake || cpuTake) begin
      addr_reg <= mstTake ? mstReqAddr : cpuReqAddr;
      wr_reg <= mstTake ? mstReqWrite : cpuReqWrite;
      l2Hit_reg <= l2Hit;
      vicTag_reg <= rdTag;
      snooped_reg <= mstTake && !filterHit;
    end
  end

  // snoop window, modified hit flag and castout beat tracking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_reg <= 3'h0;
      modifiedLineHit_reg <= 1'b0;
      beat_reg <= 2'h0;
      beatPend_reg <= 1'b0;
    end else begin
      if (state_reg == ST_SN_STROBE) wait_reg <= MODIFIED_HIT_N_WINDOW;
      else if (wait_reg != 3'h0) wait_reg <= wait_reg - 3'h1;
      if (mstTake) modifiedLineHit_reg <= 1'b0;
      else if (state_reg == ST_SN_WAIT && hitMSync) modifiedLineHit_reg <= 1'b1;
      if (mstTake) beat_reg <= 2'h0;
      else if (state_reg == ST_SN_CASTOUT && opDone) beat_reg <= beat_reg + 2'h1;
      // a new beat wins over the clear of the previous one
      if (beatSync) beatPend_reg <= 1'b1;
      else if (state_reg == ST_SN_CASTOUT && opDone) beatPend_reg <= 1'b0;
    end
  end

  // snooped line memory; any processor cycle may re-cache it in l1
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filtValid_reg <= 1'b0;
      filtLine_reg <= '0;
    end else if (cpuTake) begin
      filtValid_reg <= 1'b0;
    end else if (state_reg == ST_RELEASE && snooped_reg) begin
      filtValid_reg <= 1'b1;
      filtLine_reg <= addr_reg[ADDR_W-1:LINE_W];
    end
  end

  // processor bus pins decoded from the registered state
  assign busBackoffN = state_reg != ST_SN_BACKOFF;
  // hold released once the master cycle is done
  assign addressHold = snooped_reg && !(state_reg inside
    {ST_IDLE, ST_SN_BACKOFF, ST_RELEASE});
  assign externalSnoopStrobeN = state_reg != ST_SN_STROBE;
  assign snoopAddr = addr_reg;
  assign snoopAddrOe = state_reg inside {ST_SN_STROBE, ST_SN_WAIT};
  // every inquire invalidates the l1 line
  assign snoopInvalidate = snoopAddrOe;
  assign cpuReqDone = opDone && (state_reg inside {ST_CPU_FILL, ST_CPU_DRAM}
    || (state_reg == ST_CPU_L2 && !(wr_reg && wthru)));
  assign mstReqDone = state_reg == ST_RELEASE;
  assign regs.status = {4'h0, filtValid_reg, modifiedLineHit_reg,
    state_reg != ST_IDLE, addressHold};

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  strobe_one_clk_a: assert property (
    $fell(externalSnoopStrobeN) |=> externalSnoopStrobeN && addressHold)
    else $error("snoop strobe not a single clock");
  strobe_after_hold_a: assert property (
    !externalSnoopStrobeN |-> $past(holdAckSync) && !$past(busBackoffN))
    else $error("snoop strobe without hold acknowledge");
  op_decode_a: assert property (
    cpuTake && opField != OP_ENABLE |=> state_reg == ST_CPU_DRAM)
    else $error("non-enabled mode used the cache");
  tag_write_a: assert property (
    cpuTake && opField == OP_TAG_WRITE |-> tagWrEn && tagWrTag == regs.tagTest)
    else $error("tag test value not written");
  tag_read_a: assert property (
    cpuTake && opField == OP_TAG_READ |-> regs.capValid && regs.capData == rdTag)
    else $error("tag not captured");
  castout_first_a: assert property (
    state_reg == ST_CPU_CASTOUT && cmdDone |=> state_reg == ST_CPU_FILL)
    else $error("linefill not after castout");
  inquire_start_a: assert property (
    mstTake && !filterHit |=> !busBackoffN)
    else $error("master access without inquire");
  filter_skip_a: assert property (
    mstTake && filterHit |=> state_reg == ST_MST_MEM ##1 !addressHold)
    else $error("filtered access still snooped");
  modified_hit_n_castout_a: assert property (
    state_reg == ST_SN_WAIT && hitMSync |=> state_reg == ST_SN_CASTOUT)
    else $error("modified hit ignored");
  burst_order_a: assert property (
    state_reg == ST_SN_CASTOUT && cmdValid && beat_reg == 2'h0 |->
      cmdAddr[ADDR_W-1:CHUNK_LSB] == addr_reg[ADDR_W-1:CHUNK_LSB])
    else $error("castout out of burst order");
  read_source_a: assert property (
    state_reg == ST_MST_MEM && !wr_reg |->
      cmdKind == (l2Hit_reg ? CMD_L2_RD : CMD_DRAM_RD))
    else $error("master read from wrong source");
  write_thru_a: assert property (
    state_reg == ST_MST_MEM && wr_reg |-> cmdKind == CMD_DRAM_WR)
    else $error("master write missed dram");
  l2_hit_only_a: assert property (
    state_reg == ST_MST_L2W |-> l2Hit_reg && $past(wr_reg))
    else $error("l2 written on master miss");
  hold_release_a: assert property (
    mstReqDone |-> !addressHold ##1 state_reg == ST_IDLE)
    else $error("address hold kept after master cycle");
endmodule // lcs_snoop_ctrl

// ### verif/lcs_far_model.sv
// far side model: processor bus and memory responder
`timescale 1ns/1ns
module lcs_far_model (
  // system
  input wire logic clk,
  // processor bus
  input wire logic busBackoffN,
  input wire logic externalSnoopStrobeN,
  input wire logic giveHitm,
  output logic holdAcknowledge,
  output logic modifiedHitN,
  output logic castoutBeat,
  // memory side
  input wire logic cmdValid,
  output logic cmdDone
);
  int t = 0;
  int w = 0;
  always @(posedge clk) holdAcknowledge <= !busBackoffN;
  always @(posedge clk) begin
    if (t > 0) t <= (t == 42) ? 0 : t + 1;
    else if (!externalSnoopStrobeN && giveHitm) t <= 1;
  end
  assign modifiedHitN = !(t > 0 && t <= 40);
  assign castoutBeat = t >= 8 && t < 40 && t[2:1] == 2'h2;
  // memory answers after zero to two cycles
  always @(posedge clk) begin
    if (cmdValid && !cmdDone && w == 0) begin
      cmdDone <= 1'h1;
      w <= $urandom_range(2, 0);
    end else begin
      cmdDone <= 1'h0;
      if (cmdValid && w > 0) w <= w - 1;
    end
  end
endmodule // lcs_far_model

// ### verif/tb.sv
// self-checking bench for the l2 snoop controller
`timescale 1ns/1ns
module tb import lcs_pkg::*; ();
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
  logic bready = 1'h1, rready = 1'h1, giveHitm = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, cmdValid, cmdDone;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0, tg;
  logic [31:0] wdata = 32'h0, rdata, snoopAddr, cmdAddr, seq, rd, e;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, rr;
  logic busBackoffN, holdAcknowledge, addressHold, externalSnoopStrobeN;
  logic modifiedHitN, castoutBeat, snoopAddrOe, snoopInvalidate;
  logic cpuReqValid = 1'h0, cpuReqWrite, mstReqValid = 1'h0, mstReqWrite;
  logic [31:0] cpuReqAddr = 32'h0, mstReqAddr = 32'h0;
  logic cpuReqDone, mstReqDone;
  lcs_cmd_t cmdKind;
  logic [9:0] ix;
  logic [1:0] ck;
  logic [31:0] cl, ce, fa;
  int err_count = 0, tests_run = 0, nStr = 0, n0;
  lcs_snoop_ctrl dut (.*);
  lcs_far_model far (.*);
  initial forever #5 clk = ~clk;
  task automatic final_report;
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] v, logic [31:0] x);
    tests_run++;
    if (v !== x) begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", s, x, v);
    end
  endtask
  // a wait that runs too long ends the run
  task automatic lim(int n);
    if (n > 300) begin
      err_count++;
      final_report;
    end
  endtask
  task automatic axw(logic [7:0] a, logic [7:0] d);
    int n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      lim(n++);
    end while (awvalid || wvalid || !bvalid);
    rr = bresp;
  endtask
  task automatic axr(logic [7:0] a);
    int n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
      lim(n++);
    end while (arvalid || !rvalid);
    rd = rdata;
    rr = rresp;
  endtask
  // one processor or master cycle, memory commands logged meanwhile
  task automatic req(logic m, logic w, logic [31:0] a);
    int n = 0;
    seq = 32'h0;
    cl = 32'h0;
    cpuReqWrite <= w;
    cpuReqAddr <= a;
    mstReqWrite <= w;
    mstReqAddr <= a;
    cpuReqValid <= !m;
    mstReqValid <= m;
    do begin
      @(posedge clk);
      lim(n++);
    end while (!(m ? mstReqDone : cpuReqDone));
    if (m) chk("hold", addressHold, 32'h0);
    cpuReqValid <= 1'h0;
    mstReqValid <= 1'h0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] ex(logic [31:0] s, lcs_cmd_t k, int n);
    for (int i = 0; i < n; i++) s = {s[28:0], {1'h0, k} + 3'h1};
    return s;
  endfunction
  function automatic logic [31:0] adr(logic [7:0] t);
    return {9'h0, t, ix, 5'h0};
  endfunction
  // chunk order of n commands, interleaved when x is set
  function automatic logic [31:0] exc(logic [31:0] s, logic [1:0] c, int n,
    logic x);
    for (int b = 0; b < n; b++) s = {s[29:0], (x ? c ^ 2'(b) : c)};
    return s;
  endfunction
  // blocking log so the caller sees it one edge later
  always @(posedge clk) begin
    if (cmdValid && cmdDone) begin
      if (seq == 32'h0) fa = cmdAddr;
      seq = {seq[28:0], {1'h0, cmdKind} + 3'h1};
      cl = {cl[29:0], cmdAddr[4:3]};
    end
    if (!externalSnoopStrobeN) begin
      nStr++;
      chk("oe", snoopAddrOe, 32'h1);
      chk("address_hold", addressHold, 32'h1);
      chk("saddr", snoopAddr, mstReqAddr);
      chk("inval", snoopInvalidate, 32'h1);
    end
  end
  initial begin
    void'($urandom(15442));
    tg = 8'($urandom);
    ix = 10'($urandom);
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    axr(8'h08);
    chk("ctrl", rd, {24'h0, RST_CTRL_ONE});
    axr(8'h1c);
    chk("tag", rd, {24'h0, RST_TAG_TEST});
    axr(8'h40);
    chk("resp", rr, RESP_SLVERR);
    axw(8'h20, 8'h5a);
    chk("ro", rr, RESP_SLVERR);
    req(0, 0, adr(tg));
    chk("off", seq, ex(0, CMD_DRAM_RD, 1));
    // tag write, readback, then writeback use
    axw(8'h1c, tg);
    axw(8'h08, 8'h04);
    chk("bresp", rr, RESP_OKAY);
    req(0, 1, adr(tg));
    chk("twr", seq, ex(0, CMD_DRAM_WR, 1));
    axw(8'h1c, 8'h0);
    axw(8'h08, 8'h08);
    req(0, 0, adr(tg));
    axr(8'h1c);
    chk("trd", rd, {24'h0, tg});
    axw(8'h08, 8'h0c);
    req(0, 1, adr(tg));
    chk("whit", seq, ex(0, CMD_L2_WR, 1));
    req(0, 0, adr(tg + 8'h1));
    e = ex(ex(0, CMD_DRAM_WR, 1), CMD_DRAM_RD, 1);
    chk("cast", seq, e);
    chk("vaddr", fa, adr(tg));
    // write-through hit goes to l2 and on to dram
    axw(8'h08, 8'h3c);
    req(0, 1, adr(tg + 8'h1));
    e = ex(ex(0, CMD_L2_WR, 1), CMD_DRAM_WR, 1);
    chk("wthru", seq, e);
    // master read and write, with and without modified hit, l2 hit or miss
    for (int i = 0; i < 8; i++) begin
      giveHitm <= i[1];
      n0 = nStr;
      ck = 2'($urandom);
      req(1, i[0], adr(tg + (i[2] ? 8'h2 : 8'h1)) | {27'h0, ck, 3'h0});
      e = ex(0, i[2] ? CMD_DRAM_WR : CMD_L2_WR, i[1] ? 4 : 0);
      if (!i[0]) e = ex(e, i[2] ? CMD_DRAM_RD : CMD_L2_RD, 1);
      else e = ex(ex(e, CMD_DRAM_WR, 1), CMD_L2_WR, !i[2]);
      chk("mst", seq, e);
      chk("inq", nStr - n0, 32'h1);
      ce = exc(exc(0, ck, i[1] ? 4 : 0, 1'h1), ck, i[0] ? 2 - i[2] : 1, 1'h0);
      chk("chunk", cl, ce);
    end
    giveHitm <= 1'h0;
    axr(8'h20);
    chk("stat", rd, 32'hc);
    axw(8'h24, 8'h01);
    n0 = nStr;
    req(1, 0, adr(tg + 8'h3));
    req(1, 1, adr(tg + 8'h3) | 32'h8);
    chk("filt", nStr - n0, 32'h1);
    final_report;
  end
endmodule // tb
